// ===== include/strap_cfg_pkg.sv
/*
  Package for the reset strap capture and pin select block: register offsets,
  reset values, strap layout, decoded mode enums and fixed pin masks.
  Assumes a 16-pin general I/O port and an 8-bit register address.
*/
package strap_cfg_pkg;

  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] OFF_STRAP_STATUS = 8'h00;
  localparam logic [7:0] OFF_GPIO_ENABLE = 8'h04;
  localparam logic [7:0] OFF_GPIO_DIR = 8'h08;
  localparam logic [7:0] OFF_GPIO_OUT = 8'h0c;
  localparam logic [7:0] OFF_GPIO_IN = 8'h10;

  // Reset values of software registers
  localparam logic [15:0] RST_GPIO_ENABLE = 16'h0000;
  localparam logic [15:0] RST_GPIO_DIR = 16'h0000;
  localparam logic [15:0] RST_GPIO_OUT = 16'h0000;

  // Fixed roles of shared general I/O pins
  localparam logic [15:0] MASK_CLOCK_PINS = 16'h0006;
  localparam int unsigned PIN_CLK_DIV4 = 1;
  localparam int unsigned PIN_CLK_DIV6 = 2;
  localparam logic [15:0] MASK_IRQ_PINS = 16'h00f0;
  localparam logic [15:0] MASK_PCI_SHARED = 16'hfe00;

  // Cycles of stable strap sampling after device reset before locking
  localparam int unsigned STRAP_SETTLE_CYCLES = 3;

  // Boot action strap codes
  typedef enum logic [1:0] {
    BOOT_NONE = 2'b00,
    BOOT_HOST_PORT = 2'b01,
    BOOT_RESERVED = 2'b10,
    BOOT_ROM8 = 2'b11
  } boot_mode_e;

  // External memory interface clock source codes
  typedef enum logic [1:0] {
    MEMCLK_DEDICATED = 2'b00,
    MEMCLK_CPU_DIV4 = 2'b01,
    MEMCLK_CPU_DIV6 = 2'b10,
    MEMCLK_RESERVED = 2'b11
  } memif_clk_e;

  // Strap pins as one packed group; status register layout is its bit order
  typedef struct packed {
    logic pci_select_strap;
    logic byte_order_strap;
    boot_mode_e boot_select_strap;
    memif_clk_e memif_clock_select_strap;
    logic eeprom_autoinit_strap;
    logic host_width_strap;
  } strap_s;

  // Decoded device configuration driven to the rest of the chip
  typedef struct packed {
    logic host_port_enable;
    logic pci_enable;
    logic little_endian;
    boot_mode_e boot_action;
    memif_clk_e memif_clock_source;
    logic pci_load_from_eeprom;
    logic pci_use_defaults;
    logic host_port_wide;
    logic host_upper_data_enable;
    logic pci_only_pins_enable;
  } dev_cfg_s;

endpackage

// ===== rtl/strap_pin_select.sv
/*
  Reset strap capture and shared pin selection. Samples the board straps
  around device reset, holds them, decodes the device configuration and
  drives the sixteen shared general I/O pins (clock outputs, interrupt
  inputs, upper pins shared with PCI) under software enable and direction.
  Assumes straps and pin inputs are asynchronous to sys_clk, the divided
  clock sources and dev_reset come from sys_clk logic, and the pad ring
  resolves each pin from its output and output enable.
*/
`timescale 1ns/1ps
`default_nettype none

// Contract
// R1 - Sample all straps during device reset, keep them
// R2 - Select strap 0: host port on, PCI off
// R3 - PCI off: PCI-only pins held high impedance
// R4 - Select strap 1: PCI on, host, upper pins off
// R5 - Board keeps select strap valid and unchanged
// R6 - PCI off: shared pins GPIO after enable, direction
// R7 - Clock pins drive clocks until GPIO configured
// R8 - Interrupt pins come up input only
// R9 - GPIO/PCI shared pins default to no function
// R10 - Host/PCI shared pins default to host port
// R11 - Byte order strap: 0 big, 1 little
// R12 - Boot strap chooses none, host, reserved, ROM
// R13 - Memory clock strap: dedicated, div4, div6, reserved
// R14 - Autoinit strap 0: PCI uses built-in defaults
// R15 - Autoinit 1 with PCI: load from EEPROM
// R16 - Board never pulls autoinit high without PCI
// R17 - Width 0: 16-bit host, upper data Hi-Z
// R18 - Width 1: 32-bit host, all data pins
// R19 - Memory, timers, serial ports, low pins always on
// R20 - Board straps boot select to valid mode
// R21 - Enable bit 1 enables; direction 1 outputs
// R22 - Captured straps constant until next device reset
module strap_pin_select #(
  parameter int unsigned SETTLE_CYCLES = strap_cfg_pkg::STRAP_SETTLE_CYCLES
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic dev_reset,
  // Strap pins
  input wire strap_cfg_pkg::strap_s straps_in,
  // Clock sources for the clock output pins
  input wire logic clk_div4_src,
  input wire logic clk_div6_src,
  // Shared general I/O pins
  input wire logic [15:0] gpio_pin_in,
  output logic [15:0] gpio_pin_out,
  output logic [15:0] gpio_pin_oe,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Decoded configuration
  output strap_cfg_pkg::dev_cfg_s dev_cfg,
  output logic straps_locked
);
  import strap_cfg_pkg::*;

  // Counter is two bits wide, so longer settling cannot be served
  generate
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 3)
    begin : g_bad_settle
      $error("SETTLE_CYCLES must be 1 to 3");
    end
  endgenerate

  localparam logic [1:0] SETTLE_LAST = 2'(SETTLE_CYCLES - 1);

  typedef struct packed {
    strap_s strap_s1;
    strap_s strap_s2;
    strap_s strap_s3;
    strap_s captured;
    logic locked;
    logic [1:0] settle;
    logic [15:0] gpio_enable;
    logic [15:0] gpio_dir;
    logic [15:0] gpio_dout;
    logic [15:0] pin_s1;
    logic [15:0] pin_s2;
    logic [15:0] pin_s3;
    logic [15:0] pin_val;
    logic [15:0] pin_out;
    logic [15:0] pin_oe;
    logic [31:0] rdata;
    dev_cfg_s cfg;
  } state_s;

  // Default straps before the first sample: select 0, little endian,
  // reserved boot, dedicated memory clock, no autoinit, narrow host
  localparam strap_s STRAP_DEFAULT = '{1'b0, 1'b1, BOOT_RESERVED, MEMCLK_DEDICATED, 1'b0, 1'b0};

  state_s state;
  state_s next_state;

  // Register read mux, reused by the read path
  function automatic logic [31:0] read_word(input logic [7:0] addr, input state_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (addr)
      OFF_STRAP_STATUS: w = {22'h00_0000, s.locked, 1'b0, s.captured};
      OFF_GPIO_ENABLE: w = {16'h0000, s.gpio_enable};
      OFF_GPIO_DIR: w = {16'h0000, s.gpio_dir};
      OFF_GPIO_OUT: w = {16'h0000, s.gpio_dout};
      OFF_GPIO_IN: w = {16'h0000, s.pin_val};
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // Pin is a software output only when enabled and set to output
  function automatic logic [15:0] sw_drive(input logic [15:0] en, input logic [15:0] dir);
    return en & dir; // see R21
  endfunction

  // Next state: strap capture, registers, pin mux, config decode
  always_comb
  begin
    logic [15:0] drive;
    drive = 16'h0000;
    next_state = state;
    if (ce)
    begin
      // Three-stage sampling of asynchronous straps and pins
      next_state.strap_s1 = straps_in;
      next_state.strap_s2 = state.strap_s1;
      next_state.strap_s3 = state.strap_s2;
      next_state.pin_s1 = gpio_pin_in;
      next_state.pin_s2 = state.pin_s1;
      next_state.pin_s3 = state.pin_s2;
      if (state.pin_s2 == state.pin_s3)
      begin
        next_state.pin_val = state.pin_s3;
      end

      // Capture window open while device reset holds or settling runs
      if (!state.locked && state.strap_s2 == state.strap_s3)
      begin
        next_state.captured = state.strap_s3; // see R1
      end
      if (dev_reset)
      begin
        next_state.locked = 1'b0;
        next_state.settle = 2'b00;
      end
      else if (!state.locked)
      begin
        // Lock only after samples agree, so a late bounce is not frozen
        if (state.strap_s2 == state.strap_s3)
        begin
          if (state.settle == SETTLE_LAST)
          begin
            next_state.locked = 1'b1; // see R22
          end
          else
          begin
            next_state.settle = state.settle + 2'b01;
          end
        end
        else
        begin
          next_state.settle = 2'b00;
        end
      end

      // Register writes; unmapped addresses are ignored
      if (reg_wr)
      begin
        case (reg_addr)
          OFF_GPIO_ENABLE: next_state.gpio_enable = reg_wdata[15:0];
          OFF_GPIO_DIR: next_state.gpio_dir = reg_wdata[15:0];
          OFF_GPIO_OUT: next_state.gpio_dout = reg_wdata[15:0];
          default: next_state.gpio_dir = state.gpio_dir;
        endcase
      end
      // Read data valid in the following cycle only
      next_state.rdata = reg_rd ? read_word(reg_addr, state) : 32'h0000_0000;

      // Pin drive: software outputs, clocks on clock pins software leaves undriven, PCI mask last
      drive = sw_drive(state.gpio_enable, state.gpio_dir); // see R6
      next_state.pin_out = state.gpio_dout;
      next_state.pin_oe = drive; // see R8
      if (!drive[PIN_CLK_DIV4])
      begin
        next_state.pin_out[PIN_CLK_DIV4] = clk_div4_src; // see R7
        next_state.pin_oe[PIN_CLK_DIV4] = 1'b1;
      end
      if (!drive[PIN_CLK_DIV6])
      begin
        next_state.pin_out[PIN_CLK_DIV6] = clk_div6_src; // see R7
        next_state.pin_oe[PIN_CLK_DIV6] = 1'b1;
      end
      // Upper pins belong to PCI when it is selected
      if (state.captured.pci_select_strap)
      begin
        next_state.pin_oe = next_state.pin_oe & ~MASK_PCI_SHARED; // see R4, R19
      end

      // Configuration decode from the held straps
      next_state.cfg.host_port_enable = !state.captured.pci_select_strap; // see R2
      next_state.cfg.pci_enable = state.captured.pci_select_strap; // see R4
      next_state.cfg.little_endian = state.captured.byte_order_strap; // see R11
      next_state.cfg.boot_action = state.captured.boot_select_strap; // see R12
      next_state.cfg.memif_clock_source = state.captured.memif_clock_select_strap; // see R13
      next_state.cfg.pci_load_from_eeprom = state.captured.pci_select_strap
        & state.captured.eeprom_autoinit_strap; // see R15
      next_state.cfg.pci_use_defaults = !(state.captured.pci_select_strap
        & state.captured.eeprom_autoinit_strap); // see R14
      next_state.cfg.host_port_wide = state.captured.host_width_strap; // see R18
      next_state.cfg.host_upper_data_enable = !state.captured.pci_select_strap
        & state.captured.host_width_strap; // see R17
      next_state.cfg.pci_only_pins_enable = state.captured.pci_select_strap; // see R3
    end
  end

  // State register; reset gives host port, no GPIO, inputs only
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= '0;
      state.strap_s1 <= STRAP_DEFAULT;
      state.strap_s2 <= STRAP_DEFAULT;
      state.strap_s3 <= STRAP_DEFAULT;
      state.captured <= STRAP_DEFAULT;
      state.gpio_enable <= RST_GPIO_ENABLE; // see R9
      state.gpio_dir <= RST_GPIO_DIR;
      state.gpio_dout <= RST_GPIO_OUT;
      state.cfg.host_port_enable <= 1'b1; // see R10
      state.cfg.little_endian <= 1'b1;
      state.cfg.boot_action <= BOOT_RESERVED;
      state.cfg.memif_clock_source <= MEMCLK_DEDICATED;
      state.cfg.pci_use_defaults <= 1'b1;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Outputs straight from the state register
  assign gpio_pin_out = state.pin_out;
  assign gpio_pin_oe = state.pin_oe;
  assign reg_rdata = state.rdata;
  assign dev_cfg = state.cfg;
  assign straps_locked = state.locked;

  // Checks of the captured configuration and the pin mux
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  property p_capture;
    ce && !state.locked && state.strap_s2 == state.strap_s3 |=> state.captured == $past(state.strap_s3);
  endproperty
  a_capture: assert property (p_capture) else $error("strap not captured while open"); // see R1

  property p_hold;
    state.locked && !dev_reset |=> $stable(state.captured);
  endproperty
  a_hold: assert property (p_hold) else $error("captured straps changed while locked"); // see R22

  property p_host_sel;
    ce && !state.captured.pci_select_strap |=> dev_cfg.host_port_enable && !dev_cfg.pci_enable;
  endproperty
  a_host_sel: assert property (p_host_sel) else $error("host port not selected"); // see R2

  property p_pci_sel;
    ce && state.captured.pci_select_strap |=> dev_cfg.pci_enable && (gpio_pin_oe & MASK_PCI_SHARED) == 16'h0000;
  endproperty
  a_pci_sel: assert property (p_pci_sel) else $error("upper pins driven with PCI selected"); // see R4

  property p_sw_drive;
    ce |=> (gpio_pin_oe & ~MASK_CLOCK_PINS & ~($past(state.gpio_enable) & $past(state.gpio_dir))) == 16'h0000;
  endproperty
  a_sw_drive: assert property (p_sw_drive) else $error("pin driven without enable and direction"); // see R21

  property p_clock_pin;
    ce && !(state.gpio_enable[PIN_CLK_DIV4] && state.gpio_dir[PIN_CLK_DIV4])
      |=> gpio_pin_oe[PIN_CLK_DIV4] && gpio_pin_out[PIN_CLK_DIV4] == $past(clk_div4_src);
  endproperty
  a_clock_pin: assert property (p_clock_pin) else $error("clock pin not carrying clock"); // see R7

  property p_eeprom;
    ce |=> dev_cfg.pci_load_from_eeprom == ($past(state.captured.pci_select_strap)
      && $past(state.captured.eeprom_autoinit_strap)) && dev_cfg.pci_use_defaults != dev_cfg.pci_load_from_eeprom;
  endproperty
  a_eeprom: assert property (p_eeprom) else $error("autoinit decode wrong"); // see R15

  property p_width;
    ce |=> dev_cfg.host_upper_data_enable == (!$past(state.captured.pci_select_strap)
      && $past(state.captured.host_width_strap));
  endproperty
  a_width: assert property (p_width) else $error("upper host data enable wrong"); // see R17

  property p_status_read;
    ce && reg_rd && reg_addr == OFF_STRAP_STATUS |=> reg_rdata[7:0] == $past(state.captured);
  endproperty
  a_status_read: assert property (p_status_read) else $error("strap status read wrong"); // see R1

  property p_unlock;
    ce && dev_reset |=> !straps_locked;
  endproperty
  a_unlock: assert property (p_unlock) else $error("straps stayed locked in device reset"); // see R1

  property p_lock;
    ce && !dev_reset && !state.locked && state.settle == SETTLE_LAST && state.strap_s2 == state.strap_s3
      |=> straps_locked;
  endproperty
  a_lock: assert property (p_lock) else $error("straps not locked after settling"); // see R22

  property p_cfg_copy;
    ce |=> dev_cfg.little_endian == $past(state.captured.byte_order_strap)
      && dev_cfg.boot_action == $past(state.captured.boot_select_strap)
      && dev_cfg.memif_clock_source == $past(state.captured.memif_clock_select_strap);
  endproperty
  a_cfg_copy: assert property (p_cfg_copy) else $error("order, boot or memory clock decode wrong"); // see R12

  property p_pci_pins;
    ce |=> dev_cfg.pci_only_pins_enable == $past(state.captured.pci_select_strap);
  endproperty
  a_pci_pins: assert property (p_pci_pins) else $error("PCI-only pins enable wrong"); // see R3

  property p_low_pins;
    ce |=> gpio_pin_oe[8:0] == (($past(state.gpio_enable[8:0]) & $past(state.gpio_dir[8:0])) | MASK_CLOCK_PINS[8:0]);
  endproperty
  a_low_pins: assert property (p_low_pins) else $error("low pins depend on straps"); // see R19

  property p_eeprom_off;
    ce && !state.captured.eeprom_autoinit_strap |=> dev_cfg.pci_use_defaults;
  endproperty
  a_eeprom_off: assert property (p_eeprom_off) else $error("built-in PCI defaults not used"); // see R14

  c_lock: cover property (dev_reset ##1 !dev_reset [*3] ##1 state.locked);
  c_pci_eeprom: cover property (state.locked && dev_cfg.pci_load_from_eeprom);
  c_gpio_out: cover property (gpio_pin_oe[9] && !dev_cfg.pci_enable);
  c_wide: cover property (dev_cfg.host_upper_data_enable);

endmodule

`default_nettype wire

// ===== verification/board_straps.sv
/*
  Board strap resistors: presents the fitted pull levels on the strap pins.
  Assumes the bench only picks strap sets that a legal board could carry.
*/
`timescale 1ns/1ps
`default_nettype none
module board_straps (
  // Resistor set chosen for this run
  input wire strap_cfg_pkg::strap_s fitted,
  // Strap pins seen by the device
  output strap_cfg_pkg::strap_s straps_out
);
  import strap_cfg_pkg::*;
  // Pulled lines never float, so every strap is a valid level at all times
  assign straps_out = fitted;
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
/*
  Self-checking bench for strap_pin_select: capture, decode, lock, shared pins.
  Assumes the board model supplies straps and ce stays high except in the freeze scenario.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import strap_cfg_pkg::*;
  logic sys_clk, rst_n, ce, dev_reset, clk_div4_src, clk_div6_src, reg_wr, reg_rd, straps_locked;
  logic [15:0] gpio_pin_in, gpio_pin_out, gpio_pin_oe;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  strap_s fitted, straps_in;
  dev_cfg_s dev_cfg;
  int error_cnt = 0;
  int tests_run = 0;
  int cycles = 0;
  // Strap sets reaching every valid boot code and every memory clock code
  strap_s table_v [4] = '{8'h00, 8'h55, 8'hba, 8'hfd};

  board_straps board_straps_inst (.fitted(fitted), .straps_out(straps_in));
  strap_pin_select #(.SETTLE_CYCLES(3)) strap_pin_select_inst (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
    .dev_reset(dev_reset), .straps_in(straps_in), .clk_div4_src(clk_div4_src), .clk_div6_src(clk_div6_src),
    .gpio_pin_in(gpio_pin_in), .gpio_pin_out(gpio_pin_out), .gpio_pin_oe(gpio_pin_oe), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dev_cfg(dev_cfg),
    .straps_locked(straps_locked));

  // 125 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Hang guard, far above the fewer than two hundred cycles the run needs
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      $display("BAD %0t %s", $time, what);
      error_cnt++;
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe edge
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Pulse device reset with new straps, then wait for the lock
  task automatic apply_straps(input strap_s s);
    int n;
    @(posedge sys_clk);
    dev_reset <= 1'b1;
    fitted <= s;
    repeat (4) @(posedge sys_clk);
    dev_reset <= 1'b0;
    n = 0;
    while (straps_locked !== 1'b1 && n < 50)
    begin
      @(posedge sys_clk);
      n++;
    end
    repeat (2) @(posedge sys_clk);
    #1;
    check(32'(straps_locked), 32'h1, "no lock");
  endtask

  function automatic dev_cfg_s expect_cfg(input strap_s s);
    dev_cfg_s e;
    e.host_port_enable = ~s.pci_select_strap;
    e.pci_enable = s.pci_select_strap;
    e.little_endian = s.byte_order_strap;
    e.boot_action = s.boot_select_strap;
    e.memif_clock_source = s.memif_clock_select_strap;
    e.pci_load_from_eeprom = s.pci_select_strap & s.eeprom_autoinit_strap;
    e.pci_use_defaults = ~e.pci_load_from_eeprom;
    e.host_port_wide = s.host_width_strap;
    e.host_upper_data_enable = ~s.pci_select_strap & s.host_width_strap;
    e.pci_only_pins_enable = s.pci_select_strap;
    return e;
  endfunction

  task automatic test_reset_defaults();
    repeat (2) @(posedge sys_clk);
    #1;
    check(32'(gpio_pin_oe & MASK_IRQ_PINS), 32'h0, "irq pins drive");
    check(32'(gpio_pin_oe & MASK_PCI_SHARED), 32'h0, "shared pins drive");
    check(32'(gpio_pin_oe & MASK_CLOCK_PINS), 32'h6, "clock pins idle");
    check({20'h0, dev_cfg}, {20'h0, expect_cfg(8'h60)}, "reset config");
  endtask

  // Every strap set: decode, status readback, then a strap change after lock
  task automatic test_decode();
    dev_cfg_s e;
    foreach (table_v[i])
    begin
      apply_straps(table_v[i]);
      e = expect_cfg(table_v[i]);
      check({20'h0, dev_cfg}, {20'h0, e}, "decode");
      reg_read(OFF_STRAP_STATUS, rd_val);
      check(rd_val, {22'h0, 2'b10, table_v[i]}, "status");
      fitted <= table_v[i] ^ 8'h4d;
      repeat (10) @(posedge sys_clk);
      #1;
      check({20'h0, dev_cfg}, {20'h0, e}, "moved after lock");
    end
  endtask

  task automatic test_pins();
    apply_straps(table_v[0]);
    reg_write(OFF_GPIO_OUT, 32'h0000_0200);
    reg_write(OFF_GPIO_ENABLE, 32'h0000_0202);
    reg_write(OFF_GPIO_DIR, 32'h0000_0202);
    repeat (2) @(posedge sys_clk);
    #1;
    check(32'(gpio_pin_oe & 16'h0206), 32'h0206, "pin enables");
    check(32'(gpio_pin_out & 16'h0206), 32'h0204, "pin levels");
    @(posedge sys_clk);
    clk_div6_src <= 1'b0;
    gpio_pin_in <= 16'h0200;
    repeat (2) @(posedge sys_clk);
    #1;
    check(32'(gpio_pin_out[PIN_CLK_DIV6]), 32'h0, "clock pin stuck");
    reg_write(OFF_GPIO_DIR, 32'h0);
    repeat (8) @(posedge sys_clk);
    reg_read(OFF_GPIO_IN, rd_val);
    check(rd_val & 32'h0200, 32'h0200, "pin input");
    check(32'(gpio_pin_oe[9]), 32'h0, "input pin drives");
    reg_write(OFF_STRAP_STATUS, 32'hffff_ffff);
    reg_read(8'h40, rd_val);
    check(rd_val, 32'h0, "unmapped read");
    reg_read(OFF_STRAP_STATUS, rd_val);
    check(rd_val, {22'h0, 2'b10, table_v[0]}, "status written");
    apply_straps(table_v[2]);
    reg_write(OFF_GPIO_ENABLE, 32'h0000_0201);
    reg_write(OFF_GPIO_DIR, 32'h0000_0201);
    repeat (2) @(posedge sys_clk);
    #1;
    check(32'(gpio_pin_oe & 16'h0201), 32'h0001, "pci pin as gpio");
  endtask

  // Clock enable low: a register write must leave no trace
  task automatic test_freeze();
    @(posedge sys_clk);
    ce <= 1'b0;
    reg_write(OFF_GPIO_OUT, 32'h0000_0001);
    ce <= 1'b1;
    reg_read(OFF_GPIO_OUT, rd_val);
    check(rd_val, 32'h0000_0200, "write taken with ce low");
  endtask

  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    dev_reset = 1'b0;
    fitted = 8'h40;
    clk_div4_src = 1'b1;
    clk_div6_src = 1'b1;
    gpio_pin_in = 16'h0000;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    test_reset_defaults();
    test_decode();
    test_pins();
    test_freeze();
    print_verdict();
  end
endmodule
`default_nettype wire
